// ==== hdl/twfp_write_port.sv ====
// Purpose: Wide write port of the transmit line buffer with eight partitions.
// Assumes: Fabric writer and line reader share ref_clk; no software registers.
// Notes: The first write of a line fills the upper half, the second the lower half.
`timescale 1ns/1ps
module twfp_write_port (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fabric write side.
  input wire logic [twfp_pkg::PART_W-1:0] wide_partition_select,
  input wire logic [twfp_pkg::WORD_W-1:0] wide_write_word,
  input wire logic [twfp_pkg::MASK_W-1:0] wide_byte_valid_mask,
  input wire logic wide_packet_start_flag,
  input wire logic wide_packet_end_flag,
  input wire logic wide_packet_error_flag,
  input wire logic wide_write_strobe,
  input wire logic wide_line_terminate,
  output logic wide_write_ready,
  // Port to partition map, three bits per logical port.
  input wire logic [twfp_pkg::PORTS*twfp_pkg::PART_W-1:0] cfg_port_part_map,
  // Line drain side.
  input wire logic line_read_req,
  input wire logic [twfp_pkg::PORT_W-1:0] line_read_port,
  output logic line_read_valid,
  output logic [twfp_pkg::LINE_W-1:0] line_read_data,
  output twfp_pkg::twfp_meta_t line_read_meta,
  output logic line_read_empty
);
  localparam int unsigned WR_W = $bits(twfp_pkg::twfp_wr_t);

  logic rst_meta_ff;
  logic rst_sync_ff;
  twfp_pkg::twfp_wr_t in_wr;
  twfp_pkg::twfp_wr_t head;
  logic [WR_W-1:0] head_bits;
  logic buf_valid;
  logic buf_ready;
  logic in_ready;
  logic accept;
  logic do_write;
  logic commit;
  logic hd_half;
  logic [twfp_pkg::RAM_AW-1:0] wr_addr;
  logic [twfp_pkg::PART_W-1:0] rd_part;
  logic [twfp_pkg::RAM_AW-1:0] rd_addr;
  logic rd_hit;
  logic [twfp_pkg::LINE_W-1:0] ram_ff [twfp_pkg::RAM_LINES];
  twfp_pkg::twfp_meta_t meta_ff [twfp_pkg::RAM_LINES];
  logic [twfp_pkg::LINE_IDX_W-1:0] wptr_ff [twfp_pkg::PARTS];
  logic [twfp_pkg::LINE_IDX_W-1:0] rptr_ff [twfp_pkg::PARTS];
  logic [twfp_pkg::CNT_W-1:0] lines_ff [twfp_pkg::PARTS];
  logic half_ff [twfp_pkg::PARTS];
  logic line_read_valid_ff;
  logic line_read_empty_ff;
  logic [twfp_pkg::LINE_W-1:0] line_read_data_ff;
  twfp_pkg::twfp_meta_t line_read_meta_ff;

  // Picks the partition that a logical port is mapped onto.
  function automatic logic [twfp_pkg::PART_W-1:0] part_of(
    input logic [twfp_pkg::PORTS*twfp_pkg::PART_W-1:0] map,
    input logic [twfp_pkg::PORT_W-1:0] port
  );
    part_of = map[port*twfp_pkg::PART_W +: twfp_pkg::PART_W];
  endfunction

  // Reset release through two flip-flops; the asserting edge stays asynchronous.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // A terminate alone is also a buffer entry, so it keeps its place among writes.
  always_comb begin
    in_wr.part = wide_partition_select;
    in_wr.word = wide_write_word;
    in_wr.mask = wide_byte_valid_mask;
    in_wr.sop = wide_packet_start_flag;
    in_wr.eop = wide_packet_end_flag;
    in_wr.err = wide_packet_error_flag;
    in_wr.term = wide_line_terminate;
    in_wr.strobe = wide_write_strobe;
  end

  twfp_pair_buf #(
    .W(WR_W)
  ) u_in_buf (
    .clk(ref_clk),
    .rst_n(rst_sync_ff),
    .in_valid(wide_write_strobe | wide_line_terminate),
    .in_data(in_wr),
    .in_ready(in_ready),
    .out_valid(buf_valid),
    .out_data(head_bits),
    .out_ready(buf_ready)
  );

  assign wide_write_ready = in_ready;
  assign head = twfp_pkg::twfp_wr_t'(head_bits);
  assign hd_half = half_ff[head.part];

  // Full partition stalls.
  // A partition at its doubled capacity holds the head word, which backs up to the writer.
  assign buf_ready = (lines_ff[head.part] != twfp_pkg::PART_CAP);
  assign accept = buf_valid & buf_ready;

  assign do_write = accept & head.strobe & (head.mask != twfp_pkg::MASK_NONE);

  // A line closes on its second half, on an end flag, or on a terminate.
  assign commit = accept & (head.term | (do_write & (hd_half | head.eop)));

  assign wr_addr = {head.part, wptr_ff[head.part]};

  // Byte lane enables.
  // Only the masked bytes are written; other bytes of the half keep old contents.
  always_ff @(posedge ref_clk) begin
    if (do_write) begin
      for (int b = 0; b < int'(twfp_pkg::MASK_W); b++) begin
        if (head.mask[b]) begin
          ram_ff[wr_addr][(hd_half ? 0 : twfp_pkg::HI_BASE) + 8*b +: 8] <= head.word[8*b +: 8];
        end
      end
    end
  end

  // Line side information; the first half resets it, the second half adds to it.
  // A terminate on an empty half clears it, else the drain would see a stale line's flags.
  always_ff @(posedge ref_clk) begin
    if (do_write) begin
      if (!hd_half) begin
        meta_ff[wr_addr] <= '{mask_hi: head.mask, mask_lo: twfp_pkg::MASK_NONE,
                              sop: head.sop, eop: head.eop, err: head.err};
      end else begin
        meta_ff[wr_addr].mask_lo <= head.mask;
        meta_ff[wr_addr].eop <= head.eop;
        meta_ff[wr_addr].err <= meta_ff[wr_addr].err | head.err;
      end
    end else if (accept && head.term && !hd_half) begin
      meta_ff[wr_addr] <= '0;
    end
  end

  // Terminate advances pointer.
  // Half and write pointer of the addressed partition only.
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int p = 0; p < int'(twfp_pkg::PARTS); p++) begin
        wptr_ff[p] <= '0;
        half_ff[p] <= 1'b0;
      end
    end else if (accept) begin
      if (commit) begin
        wptr_ff[head.part] <= wptr_ff[head.part] + 3'h1;
        half_ff[head.part] <= 1'b0;
      end else if (do_write) begin
        half_ff[head.part] <= 1'b1;
      end
    end
  end

  // Shared partition lookup.
  // The drain asks by logical port; several ports may land on one partition.
  assign rd_part = part_of(cfg_port_part_map, line_read_port);
  assign rd_hit = line_read_req & (lines_ff[rd_part] != 4'h0);
  assign rd_addr = {rd_part, rptr_ff[rd_part]};

  // Committed line counts; a line being closed is not visible to a read that cycle.
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int p = 0; p < int'(twfp_pkg::PARTS); p++) begin
        lines_ff[p] <= '0;
        rptr_ff[p] <= '0;
      end
    end else begin
      for (int p = 0; p < int'(twfp_pkg::PARTS); p++) begin
        lines_ff[p] <= lines_ff[p]
                       + {3'h0, (commit && head.part == PART_W_CAST(p))}
                       - {3'h0, (rd_hit && rd_part == PART_W_CAST(p))};
        if (rd_hit && rd_part == PART_W_CAST(p)) begin
          rptr_ff[p] <= rptr_ff[p] + 3'h1;
        end
      end
    end
  end

  // Narrows a loop index to a partition number.
  function automatic logic [twfp_pkg::PART_W-1:0] PART_W_CAST(input int idx);
    PART_W_CAST = idx[twfp_pkg::PART_W-1:0];
  endfunction

  // Drain answers are registered one cycle after the request.
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      line_read_valid_ff <= 1'b0;
      line_read_empty_ff <= 1'b0;
      line_read_data_ff <= '0;
      line_read_meta_ff <= '0;
    end else begin
      line_read_valid_ff <= rd_hit;
      line_read_empty_ff <= line_read_req & ~rd_hit;
      if (rd_hit) begin
        line_read_data_ff <= ram_ff[rd_addr];
        line_read_meta_ff <= meta_ff[rd_addr];
      end
    end
  end

  assign line_read_valid = line_read_valid_ff;
  assign line_read_empty = line_read_empty_ff;
  assign line_read_data = line_read_data_ff;
  assign line_read_meta = line_read_meta_ff;

  // Helper copies taken every cycle for the checks below.
  logic [twfp_pkg::RAM_AW-1:0] chk_addr_ff;
  logic [twfp_pkg::WORD_W-1:0] chk_word_ff;
  logic chk_hi_ff;
  logic [twfp_pkg::PART_W-1:0] chk_part_ff;
  logic [twfp_pkg::LINE_IDX_W-1:0] chk_wptr_ff;
  logic [twfp_pkg::LINE_IDX_W-1:0] chk_oth_ff;
  logic chk_half_ff;
  logic chk_rd_ok_ff;
  always_ff @(posedge ref_clk) begin
    chk_addr_ff <= wr_addr;
    chk_word_ff <= head.word;
    chk_hi_ff <= ~hd_half;
    chk_part_ff <= head.part;
    chk_wptr_ff <= wptr_ff[head.part];
    chk_oth_ff <= wptr_ff[head.part ^ 3'h1];
    chk_half_ff <= hd_half;
    chk_rd_ok_ff <= (lines_ff[rd_part] != 4'h0);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_ff);

  sequence s_term_taken;
    accept && head.term;
  endsequence
  sequence s_ptr_stepped;
    wptr_ff[chk_part_ff] == chk_wptr_ff + 3'h1 && !half_ff[chk_part_ff];
  endsequence

  a_term_ptr_step: assert property (s_term_taken |=> s_ptr_stepped)
    else $error("Terminate did not step the partition write pointer.");
  a_other_part_kept: assert property (commit |=> wptr_ff[chk_part_ff ^ 3'h1] == chk_oth_ff)
    else $error("Commit moved the pointer of another partition.");
  a_full_mask_store: assert property (do_write && head.mask == twfp_pkg::MASK_ALL |=>
    (chk_hi_ff ? ram_ff[chk_addr_ff][127:64] : ram_ff[chk_addr_ff][63:0]) == chk_word_ff)
    else $error("Strobed word was not stored in the addressed half line.");
  a_top_byte_lane: assert property (do_write && head.mask[7] |=>
    ram_ff[chk_addr_ff][(chk_hi_ff ? 127 : 63) -: 8] == chk_word_ff[63:56])
    else $error("Mask bit seven did not place the top data byte.");
  a_empty_mask_drop: assert property (accept && head.strobe
    && head.mask == twfp_pkg::MASK_NONE && !head.term
    |=> wptr_ff[chk_part_ff] == chk_wptr_ff && half_ff[chk_part_ff] == chk_half_ff)
    else $error("A write with an empty mask changed the partition state.");
  a_cap_stall: assert property (buf_valid
    && lines_ff[head.part] == twfp_pkg::PART_CAP
    |-> !accept ##1 lines_ff[chk_part_ff] <= twfp_pkg::PART_CAP)
    else $error("A full partition accepted a write or overflowed.");
  a_shared_read: assert property (line_read_req |=> line_read_valid == chk_rd_ok_ff
    && line_read_empty == !chk_rd_ok_ff)
    else $error("Drain answer does not match the mapped partition fill.");
endmodule // twfp_write_port

// ==== hdl/twfp_pkg.sv ====
// Purpose: Shared constants and carriers for the wide transmit write port.
// Assumes: One clock; the fabric writer runs on that same clock.
// Notes: Summary of operation follows.
// Summary of operation
// - Up to eight partitions, 3-bit select.
// - Wide partition holds twice the narrow entries.
// - Several logical ports may share one partition.
// - Mask bit n qualifies data byte n.
// - All-zero mask drops data, no write.
// - Data captured on each strobed edge with write ready high.
// - Line terminate advances partition write pointer.
package twfp_pkg;
  localparam int unsigned PARTS = 8;
  localparam int unsigned PART_W = 3;
  localparam int unsigned WORD_W = 64;
  localparam int unsigned MASK_W = 8;
  localparam int unsigned LINE_W = 128;
  localparam int unsigned NARROW_PART_ENTRIES = 8;
  localparam int unsigned WIDE_PART_ENTRIES = 2 * NARROW_PART_ENTRIES;
  localparam int unsigned HALVES_PER_LINE = LINE_W / WORD_W;
  localparam int unsigned LINES_PER_PART = WIDE_PART_ENTRIES / HALVES_PER_LINE;
  localparam int unsigned LINE_IDX_W = 3;
  localparam int unsigned RAM_AW = PART_W + LINE_IDX_W;
  localparam int unsigned RAM_LINES = PARTS * LINES_PER_PART;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned PORTS = 8;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned HI_BASE = 64;
  localparam logic [CNT_W-1:0] PART_CAP = 4'h8;
  localparam logic [MASK_W-1:0] MASK_NONE = 8'h00;
  localparam logic [MASK_W-1:0] MASK_ALL = 8'hff;

  // One fabric write as it travels through the input buffer.
  typedef struct packed {
    logic [PART_W-1:0] part;
    logic [WORD_W-1:0] word;
    logic [MASK_W-1:0] mask;
    logic sop;
    logic eop;
    logic err;
    logic term;
    logic strobe;
  } twfp_wr_t;

  // Per-line side information kept beside each buffer line.
  typedef struct packed {
    logic [MASK_W-1:0] mask_hi;
    logic [MASK_W-1:0] mask_lo;
    logic sop;
    logic eop;
    logic err;
  } twfp_meta_t;
endpackage

// ==== hdl/twfp_pair_buf.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, reset already synchronised by the parent.
// Notes: Input ready is registered, so a full buffer cannot take a word in the same cycle as a pop.
`timescale 1ns/1ps
module twfp_pair_buf #(
  parameter int unsigned W = 80
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] head_ff;
  logic [W-1:0] tail_ff;
  logic [1:0] count_ff;
  logic [1:0] nxt_count;
  logic in_ready_ff;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_ff;
  assign pop = (count_ff != 2'h0) & out_ready;
  assign out_valid = (count_ff != 2'h0);
  assign out_data = head_ff;
  assign in_ready = in_ready_ff;

  // Occupancy; ready is taken from the next count so full is honest.
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 2'h0;
      in_ready_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != 2'(twfp_pkg::BUF_DEPTH));
    end
  end

  // Data storage; the head always holds the oldest word.
  always_ff @(posedge clk) begin
    if (push && pop) begin
      if (count_ff == 2'h1) begin
        head_ff <= in_data;
      end else begin
        head_ff <= tail_ff;
        tail_ff <= in_data;
      end
    end else if (push) begin
      if (count_ff == 2'h0) begin
        head_ff <= in_data;
      end else begin
        tail_ff <= in_data;
      end
    end else if (pop) begin
      head_ff <= tail_ff;
    end
  end
endmodule // twfp_pair_buf

// ==== tb/twfp_writer_model.sv ====
// Purpose: Fabric-side writer model that feeds the wide write port.
// Assumes: Shares ref_clk with the port; requests change just after a rising edge.
// Notes: A released data bus shows the inverse of the last word, never a stale copy.
`timescale 1ns/1ps
module twfp_writer_model (
  // Clock and handshake.
  input wire logic ref_clk,
  input wire logic wide_write_ready,
  // Write request.
  output logic [2:0] wide_partition_select,
  output logic [63:0] wide_write_word,
  output logic [7:0] wide_byte_valid_mask,
  output logic wide_packet_start_flag,
  output logic wide_packet_end_flag,
  output logic wide_packet_error_flag,
  output logic wide_write_strobe,
  output logic wide_line_terminate,
  // Raised when a request waited too long for ready.
  output logic stuck
);
  // Everything idles low so nothing is taken before the first request.
  initial begin
    {wide_partition_select, wide_write_word, wide_byte_valid_mask} = '0;
    {wide_packet_start_flag, wide_packet_end_flag, wide_packet_error_flag} = '0;
    {wide_write_strobe, wide_line_terminate, stuck} = '0;
  end

  // halves, masks, flags.
  // The request is held until an edge samples ready high, so a stall loses no word.
  task automatic put(input logic [2:0] p, input logic [63:0] w, input logic [7:0] m,
                     input logic s, input logic e, input logic er, input logic t);
    int n;
    n = 0;
    wide_partition_select <= p;
    wide_write_word <= w;
    wide_byte_valid_mask <= m;
    wide_packet_start_flag <= s;
    wide_packet_end_flag <= e;
    wide_packet_error_flag <= er;
    wide_write_strobe <= ~t;
    wide_line_terminate <= t;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wide_write_ready !== 1'b1 && n < 400);
    if (n >= 400) stuck <= 1'b1;
  endtask

  // Releases the request; called at the edge where the last one was taken.
  task automatic idle();
    wide_write_strobe <= 1'b0;
    wide_line_terminate <= 1'b0;
    wide_write_word <= ~wide_write_word;
  endtask
endmodule // twfp_writer_model

// ==== tb/tb_tx_wide_write_fifo_port.sv ====
// Purpose: Self-checking bench for the wide write port of the transmit buffer.
// Assumes: Writer model drives the write side; the bench drives the line drain.
// Notes: Each scenario drives and judges on its own before it returns.
`timescale 1ns/1ps
module tb_tx_wide_write_fifo_port;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] map = 24'hfa_c688;
  logic req = 1'b0;
  logic [2:0] rport = 3'h0;
  logic [2:0] sel;
  logic [63:0] word;
  logic [7:0] mask;
  logic sop, eop, err, strobe, term, ready, stuck, rvalid, rempty;
  logic [127:0] rdata;
  twfp_pkg::twfp_meta_t rmeta;
  int n_errors = 0;
  int compares = 0;

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  twfp_writer_model u_wr (.ref_clk(ref_clk), .wide_write_ready(ready),
    .wide_partition_select(sel), .wide_write_word(word), .wide_byte_valid_mask(mask),
    .wide_packet_start_flag(sop), .wide_packet_end_flag(eop), .wide_packet_error_flag(err),
    .wide_write_strobe(strobe), .wide_line_terminate(term), .stuck(stuck));

  twfp_write_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wide_partition_select(sel),
    .wide_write_word(word), .wide_byte_valid_mask(mask), .wide_packet_start_flag(sop),
    .wide_packet_end_flag(eop), .wide_packet_error_flag(err), .wide_write_strobe(strobe),
    .wide_line_terminate(term), .wide_write_ready(ready), .cfg_port_part_map(map),
    .line_read_req(req), .line_read_port(rport), .line_read_valid(rvalid),
    .line_read_data(rdata), .line_read_meta(rmeta), .line_read_empty(rempty));

  // Counts every compare; a mismatch is reported at once.
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [20:0] md(input logic [7:0] hi, input logic [7:0] lo,
                                     input logic [2:0] f);
    return {hi, lo, f};
  endfunction

  // Expands a byte mask so only enabled bytes are compared.
  function automatic logic [63:0] bm(input logic [7:0] m);
    for (int i = 0; i < 8; i++) bm[8*i +: 8] = {8{m[i]}};
  endfunction

  // Requests one line; the answer stands only in the following cycle.
  task automatic rd(input logic [2:0] p, input logic emp, input logic [127:0] d,
                    input logic [127:0] dm, input logic [20:0] m);
    @(posedge ref_clk);
    req <= 1'b1;
    rport <= p;
    @(posedge ref_clk);
    req <= 1'b0;
    #1;
    check(128'(rempty), 128'(emp));
    check(128'(rvalid), 128'(!emp));
    if (!emp) begin
      check(rdata & dm, d & dm);
      check(128'(rmeta), 128'(m));
    end
  endtask

  // Releases the writer and lets buffered words commit.
  task automatic settle();
    u_wr.idle();
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic s_parts();
    @(posedge ref_clk);
    for (int p = 0; p < 8; p++) begin
      u_wr.put(3'(p), 64'h1111_0000_0000_0000 + 64'(p), 8'hff, 1'b1, 1'b0, 1'b0, 1'b0);
      u_wr.put(3'(p), 64'h2222_0000_0000_0000 + 64'(p), 8'hff, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    settle();
    for (int p = 0; p < 8; p++)
      rd(3'(p), 1'b0, {64'h1111_0000_0000_0000 + 64'(p), 64'h2222_0000_0000_0000 + 64'(p)},
         '1, md(8'hff, 8'hff, 3'b110));
  endtask

  // capacity and partial masks.
  // A full partition must stall the writer rather than overwrite its oldest line.
  task automatic s_fill();
    logic [7:0] m;
    @(posedge ref_clk);
    for (int k = 1; k <= 8; k++) begin
      m = 8'hff << (8 - k);
      u_wr.put(3'h2, 64'h3333_0000_0000_0000 + 64'(k), 8'hff, 1'b1, 1'b0, 1'b0, 1'b0);
      u_wr.put(3'h2, 64'h4444_0000_0000_0000 + 64'(k), m, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    settle();
    // Two words fill the input buffer behind the full partition; the third must wait.
    fork
      begin
        u_wr.put(3'h2, 64'h5555_0000_0000_0000, 8'hff, 1'b1, 1'b0, 1'b0, 1'b0);
        u_wr.put(3'h2, 64'h5656_0000_0000_0000, 8'hff, 1'b0, 1'b1, 1'b0, 1'b0);
        u_wr.put(3'h2, 64'h5757_0000_0000_0000, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0);
        u_wr.idle();
      end
      begin
        repeat (20) @(posedge ref_clk);
        #1;
        check(128'(ready), 128'(1'b0));
        for (int k = 1; k <= 8; k++) begin
          m = 8'hff << (8 - k);
          rd(3'h2, 1'b0, {64'h3333_0000_0000_0000 + 64'(k), 64'h4444_0000_0000_0000 + 64'(k)},
             {64'hffff_ffff_ffff_ffff, bm(m)}, md(8'hff, m, 3'b110));
        end
      end
    join
    repeat (4) @(posedge ref_clk);
    rd(3'h2, 1'b0, {64'h5555_0000_0000_0000, 64'h5656_0000_0000_0000}, '1,
       md(8'hff, 8'hff, 3'b110));
    rd(3'h2, 1'b0, {64'h5757_0000_0000_0000, 64'h0}, {64'hffff_ffff_ffff_ffff, 64'h0},
       md(8'hff, 8'h00, 3'b110));
    rd(3'h2, 1'b1, '0, '0, '0);
  endtask

  task automatic s_err_drop();
    @(posedge ref_clk);
    u_wr.put(3'h5, 64'h6666_0000_0000_0000, 8'h80, 1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    rd(3'h5, 1'b0, {64'h6666_0000_0000_0000, 64'h0}, {bm(8'h80), 64'h0},
       md(8'h80, 8'h00, 3'b111));
    @(posedge ref_clk);
    u_wr.put(3'h5, 64'h7777_0000_0000_0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    rd(3'h5, 1'b1, '0, '0, '0);
    @(posedge ref_clk);
    u_wr.put(3'h5, 64'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    settle();
    rd(3'h5, 1'b0, '0, '0, md(8'h00, 8'h00, 3'b000));
  endtask

  task automatic s_share();
    @(posedge ref_clk);
    map[18 +: 6] <= {3'h4, 3'h4};
    u_wr.put(3'h4, 64'h8888_0000_0000_0000, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0);
    u_wr.put(3'h4, 64'h9999_0000_0000_0000, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    rd(3'h6, 1'b0, {64'h8888_0000_0000_0000, 64'h0}, {64'hffff_ffff_ffff_ffff, 64'h0},
       md(8'hff, 8'h00, 3'b110));
    rd(3'h7, 1'b0, {64'h9999_0000_0000_0000, 64'h0}, {64'hffff_ffff_ffff_ffff, 64'h0},
       md(8'hff, 8'h00, 3'b110));
    rd(3'h6, 1'b1, '0, '0, '0);
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (6) @(posedge ref_clk);
    check(128'(ready), 128'(1'b0));
    check(128'(rvalid), 128'(1'b0));
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    s_parts();
    s_fill();
    s_err_drop();
    s_share();
    check(128'(stuck), 128'(1'b0));
    report_and_stop();
  end

  // Watchdog: the scenarios need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
endmodule // tb_tx_wide_write_fifo_port
